// >>> design/lsm_pkg.sv
// lane sample mapper constants: register map, field positions, lane-map mode codes
// assumes a 32-bit axi4-lite register bus and one frame-rate clock
package lsm_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int LSM_ADDR_W = 8;
  localparam logic [7:0] LSM_CTRL_OFF = 8'h00;
  localparam logic [7:0] LSM_STAT_OFF = 8'h04;
  localparam int LSM_CTRL_MODE_LSB = 0;
  localparam int LSM_MODE_W = 7;
  localparam int LSM_CTRL_EN_BIT = 8;
  localparam logic [6:0] LSM_MODE_RST = 7'h0C;
  localparam logic LSM_EN_RST = 1'b1;
  localparam int LSM_STAT_SUP_BIT = 0;
  localparam int LSM_STAT_LANES_LSB = 8;
  localparam int LSM_STAT_FCNT_LSB = 16;
  localparam logic [1:0] LSM_RESP_OKAY = 2'h0;
  localparam logic [1:0] LSM_RESP_SLVERR = 2'h2;

  // ************************************************************
  // datapath widths
  // ************************************************************
  localparam int LSM_S15_W = 15;
  localparam int LSM_S12_W = 12;
  localparam int LSM_NSAMP = 4;
  localparam int LSM_NBYP = 16;
  localparam int LSM_LANES = 8;
  localparam int LSM_LANE_W = 32;
  localparam int LSM_WORD_W = 16;

  // ************************************************************
  // lane-map mode codes
  // ************************************************************
  localparam logic [6:0] LSM_M12 = 7'h0C;
  localparam logic [6:0] LSM_M47 = 7'h2F;
  localparam logic [6:0] LSM_M13 = 7'h0D;
  localparam logic [6:0] LSM_M53 = 7'h35;
  localparam logic [6:0] LSM_M14 = 7'h0E;
  localparam logic [6:0] LSM_M39 = 7'h27;
  localparam logic [6:0] LSM_M56 = 7'h38;
  localparam logic [6:0] LSM_M59 = 7'h3B;
  localparam logic [6:0] LSM_M66 = 7'h42;
  localparam logic [6:0] LSM_M68 = 7'h44;
  localparam logic [6:0] LSM_M15 = 7'h0F;
  localparam logic [6:0] LSM_M49 = 7'h31;
  localparam logic [6:0] LSM_M57 = 7'h39;
  localparam logic [6:0] LSM_M60 = 7'h3C;
  localparam logic [6:0] LSM_M67 = 7'h43;
  localparam logic [6:0] LSM_M16 = 7'h10;
  localparam logic [6:0] LSM_M55 = 7'h37;
  localparam logic [6:0] LSM_M58 = 7'h3A;
  localparam logic [6:0] LSM_M19 = 7'h13;

  // active lane count reported per layout
  localparam logic [4:0] LSM_NL_16 = 5'h10;
  localparam logic [4:0] LSM_NL_2 = 5'h02;
  localparam logic [4:0] LSM_NL_4 = 5'h04;
  localparam logic [4:0] LSM_NL_8 = 5'h08;
  localparam logic [4:0] LSM_NL_12 = 5'h0C;

  typedef enum logic [2:0] {
    LSM_LAY_NONE = 3'h0,
    LSM_LAY_SIXTEEN = 3'h1,
    LSM_LAY_EIGHT = 3'h3,
    LSM_LAY_FOUR = 3'h2,
    LSM_LAY_TWO = 3'h6,
    LSM_LAY_BYPASS = 3'h7
  } lsm_layout_t;

endpackage

// >>> design/lsm_top.sv
// lane sample mapper: places decimated iq samples and over-range flags, or raw
// 12-bit bypass samples, onto eight lanes per channel each frame
// assumes samples arrive on the frame clock from same-domain logic, one frame per valid
// Summary of operation
// (RL1) in mode 12 every lane word holds one 15-bit sample plus one over-range flag in octets 0-1.
// (RL2) in mode 12 lanes 0-3 carry in-phase 0-3 with the first flag, lanes 4-7 quadrature 0-3 with the second, per channel.
// (RL3) mode 47 places samples and flags exactly as mode 12.
// (RL4) in mode 13 lane 0 carries in-phase 0 with first flag in octets 0-1 and quadrature 0 with second flag in octets 2-3.
// (RL5) mode 53 places samples exactly as mode 13.
// (RL6) in mode 14 lane 0 carries in-phase 0 with first flag and lane 1 quadrature 0 with second flag.
// (RL7) modes 39, 56, 59, 66 and 68 place samples exactly as mode 14.
// (RL8) in mode 15 lanes 0-1 carry in-phase 0-1 with first flag and lanes 2-3 quadrature 0-1 with second flag.
// (RL9) modes 49, 57, 60 and 67 place samples exactly as mode 15.
// (RL10) in mode 16 lanes 0-3 carry in-phase 0-3 and lanes 4-7 quadrature 0-3, one sample per lane frame.
// (RL11) modes 55 and 58 place samples exactly as mode 16.
// (RL12) in mode 19 even samples 0-14 go on channel a lanes 0-5 and odd samples 1-15 on channel b lanes 0-5.
// (RL13) in mode 19 each three lane words pack four 12-bit samples msb first as 12, 4+8, 8+4, 12 bits.
// (RL14) each 16-bit decimated lane word holds the sample in its upper 15 bits and the flag in bit 0.
// (RL15) the receiver runs the same mode and unpacks with the same lane and octet placement.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module lsm_top (
  input wire logic clk,
  input wire logic sys_rst,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sample side
  input wire logic sample_valid,
  input wire logic [59:0] chan_a_inphase_sample,
  input wire logic [59:0] chan_a_quadrature_sample,
  input wire logic [59:0] chan_b_inphase_sample,
  input wire logic [59:0] chan_b_quadrature_sample,
  input wire logic [3:0] chan_a_overrange_flag_first,
  input wire logic [3:0] chan_a_overrange_flag_second,
  input wire logic [3:0] chan_b_overrange_flag_first,
  input wire logic [3:0] chan_b_overrange_flag_second,
  input wire logic [191:0] bypass_sample,
  // lane side
  output logic lane_valid,
  output logic [7:0][31:0] chan_a_lane,
  output logic [7:0][31:0] chan_b_lane
);

  // ************************************************************
  // register bus
  // ************************************************************
  logic [6:0] mode_q;
  logic enable_q;
  logic [15:0] frame_cnt_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic arready_q;
  logic rvalid_q;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  wire aw_fire = s_axi_awvalid && awready_q;
  wire w_fire = s_axi_wvalid && wready_q;
  wire do_write = aw_held_q && w_held_q && !bvalid_q;
  wire wr_ctrl = awaddr_q == lsm_pkg::LSM_CTRL_OFF;
  wire wr_stat = awaddr_q == lsm_pkg::LSM_STAT_OFF;
  wire ar_fire = s_axi_arvalid && arready_q;
  wire rd_ctrl = s_axi_araddr == lsm_pkg::LSM_CTRL_OFF;
  wire rd_stat = s_axi_araddr == lsm_pkg::LSM_STAT_OFF;

  lsm_pkg::lsm_layout_t layout;
  logic [4:0] lane_count;
  wire supported = layout != lsm_pkg::LSM_LAY_NONE;

  // ************************************************************
  // register read words
  // ************************************************************
  // unused bits read as zero, so software may write back what it read
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  always_comb begin
    ctrl_word = 32'h00000000;
    ctrl_word[lsm_pkg::LSM_CTRL_MODE_LSB +: lsm_pkg::LSM_MODE_W] = mode_q;
    ctrl_word[lsm_pkg::LSM_CTRL_EN_BIT] = enable_q;
  end

  always_comb begin
    stat_word = 32'h00000000;
    stat_word[lsm_pkg::LSM_STAT_SUP_BIT] = supported;
    stat_word[lsm_pkg::LSM_STAT_LANES_LSB +: $bits(lane_count)] = lane_count;
    stat_word[lsm_pkg::LSM_STAT_FCNT_LSB +: $bits(frame_cnt_q)] = frame_cnt_q;
  end

  // ************************************************************
  // bus handshakes
  // ************************************************************

  // a write to status is accepted and ignored; only holes in the map error out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= lsm_pkg::LSM_RESP_OKAY;
      mode_q <= lsm_pkg::LSM_MODE_RST;
      enable_q <= lsm_pkg::LSM_EN_RST;
    end else begin
      if (aw_fire) begin
        aw_held_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      // lands one cycle after both halves are held, whichever came first
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_ctrl || wr_stat) ? lsm_pkg::LSM_RESP_OKAY : lsm_pkg::LSM_RESP_SLVERR;
        if (wr_ctrl && wstrb_q[0]) begin
          mode_q <= wdata_q[lsm_pkg::LSM_CTRL_MODE_LSB +: lsm_pkg::LSM_MODE_W];
        end
        if (wr_ctrl && wstrb_q[1]) begin
          enable_q <= wdata_q[lsm_pkg::LSM_CTRL_EN_BIT];
        end
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // address decoded at the handshake; the answer stands until rready
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= lsm_pkg::LSM_RESP_OKAY;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h00000000);
      rresp_q <= (rd_ctrl || rd_stat) ? lsm_pkg::LSM_RESP_OKAY : lsm_pkg::LSM_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ************************************************************
  // bus outputs
  // ************************************************************
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ************************************************************
  // mode decode
  // ************************************************************
  wire m_sixteen = mode_q == lsm_pkg::LSM_M12
    || mode_q == lsm_pkg::LSM_M47 // RL3
    || mode_q == lsm_pkg::LSM_M16
    || mode_q == lsm_pkg::LSM_M55 // RL11
    || mode_q == lsm_pkg::LSM_M58;
  wire m_two = mode_q == lsm_pkg::LSM_M13
    || mode_q == lsm_pkg::LSM_M53; // RL5
  wire m_four = mode_q == lsm_pkg::LSM_M14
    || mode_q == lsm_pkg::LSM_M39 // RL7
    || mode_q == lsm_pkg::LSM_M56
    || mode_q == lsm_pkg::LSM_M59
    || mode_q == lsm_pkg::LSM_M66
    || mode_q == lsm_pkg::LSM_M68;
  wire m_eight = mode_q == lsm_pkg::LSM_M15
    || mode_q == lsm_pkg::LSM_M49 // RL9
    || mode_q == lsm_pkg::LSM_M57
    || mode_q == lsm_pkg::LSM_M60
    || mode_q == lsm_pkg::LSM_M67;
  wire m_bypass = mode_q == lsm_pkg::LSM_M19;

  // decimate-by-4 and decimate-by-8 on sixteen lanes share one placement
  assign layout = m_sixteen ? lsm_pkg::LSM_LAY_SIXTEEN :
                  m_two ? lsm_pkg::LSM_LAY_TWO :
                  m_four ? lsm_pkg::LSM_LAY_FOUR :
                  m_eight ? lsm_pkg::LSM_LAY_EIGHT :
                  m_bypass ? lsm_pkg::LSM_LAY_BYPASS : lsm_pkg::LSM_LAY_NONE;

  assign lane_count = m_sixteen ? lsm_pkg::LSM_NL_16 :
                      m_two ? lsm_pkg::LSM_NL_2 :
                      m_four ? lsm_pkg::LSM_NL_4 :
                      m_eight ? lsm_pkg::LSM_NL_8 :
                      m_bypass ? lsm_pkg::LSM_NL_12 : 5'h00;

  // ************************************************************
  // sample unpacking
  // ************************************************************
  logic [14:0] inph [0:1][0:3];
  logic [14:0] quad [0:1][0:3];
  logic [3:0] flg_i [0:1];
  logic [3:0] flg_q [0:1];
  logic [11:0] byp [0:15];

  assign flg_i[0] = chan_a_overrange_flag_first;
  assign flg_i[1] = chan_b_overrange_flag_first;
  assign flg_q[0] = chan_a_overrange_flag_second;
  assign flg_q[1] = chan_b_overrange_flag_second;

  genvar k;
  generate
    for (k = 0; k < lsm_pkg::LSM_NSAMP; k++) begin : g_unpack
      assign inph[0][k] = chan_a_inphase_sample[lsm_pkg::LSM_S15_W*k +: lsm_pkg::LSM_S15_W];
      assign inph[1][k] = chan_b_inphase_sample[lsm_pkg::LSM_S15_W*k +: lsm_pkg::LSM_S15_W];
      assign quad[0][k] = chan_a_quadrature_sample[lsm_pkg::LSM_S15_W*k +: lsm_pkg::LSM_S15_W];
      assign quad[1][k] = chan_b_quadrature_sample[lsm_pkg::LSM_S15_W*k +: lsm_pkg::LSM_S15_W];
    end
    for (k = 0; k < lsm_pkg::LSM_NBYP; k++) begin : g_byp
      assign byp[k] = bypass_sample[lsm_pkg::LSM_S12_W*k +: lsm_pkg::LSM_S12_W];
    end
  endgenerate

  // ************************************************************
  // lane placement
  // ************************************************************
  logic [31:0] lane_d [0:1][0:7];

  genvar c, l;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      for (l = 0; l < lsm_pkg::LSM_LANES; l++) begin : g_lane
        localparam int SI = l % 4;
        localparam int EI = l % 2;
        localparam int G = l / 3;
        localparam int P = l % 3;
        localparam int B0 = 2 * (4 * (G % 2)) + c;
        logic [15:0] w_six;
        logic [15:0] w_eight;
        logic [15:0] w_four;
        logic [15:0] w_byp;
        logic [31:0] w_two;
        // sample in [15:1], flag in [0]
        assign w_six = (l < 4) ? {inph[c][SI], flg_i[c][SI]} // RL1 RL2 RL10 RL14
                               : {quad[c][SI], flg_q[c][SI]};
        if (l < 4) begin : g_e
          assign w_eight = (l < 2) ? {inph[c][EI], flg_i[c][EI]} // RL8
                                   : {quad[c][EI], flg_q[c][EI]};
        end else begin : g_ez
          assign w_eight = 16'h0000;
        end
        if (l < 2) begin : g_f
          assign w_four = (l == 0) ? {inph[c][0], flg_i[c][0]} // RL6
                                   : {quad[c][0], flg_q[c][0]};
        end else begin : g_fz
          assign w_four = 16'h0000;
        end
        if (l == 0) begin : g_t
          assign w_two = {inph[c][0], flg_i[c][0], quad[c][0], flg_q[c][0]}; // RL4
        end else begin : g_tz
          assign w_two = 32'h00000000;
        end
        // channel a takes even samples, channel b odd; four samples per three lanes
        if (l < 6 && P == 0) begin : g_p0
          assign w_byp = {byp[B0], byp[B0 + 2][11:8]}; // RL12 RL13
        end else if (l < 6 && P == 1) begin : g_p1
          assign w_byp = {byp[B0 + 2][7:0], byp[B0 + 4][11:4]}; // RL13
        end else if (l < 6) begin : g_p2
          assign w_byp = {byp[B0 + 4][3:0], byp[B0 + 6]}; // RL13
        end else begin : g_pz
          assign w_byp = 16'h0000;
        end
        assign lane_d[c][l] =
          (layout == lsm_pkg::LSM_LAY_SIXTEEN) ? {w_six, 16'h0000} :
          (layout == lsm_pkg::LSM_LAY_EIGHT) ? {w_eight, 16'h0000} :
          (layout == lsm_pkg::LSM_LAY_FOUR) ? {w_four, 16'h0000} :
          (layout == lsm_pkg::LSM_LAY_TWO) ? w_two :
          (layout == lsm_pkg::LSM_LAY_BYPASS) ? {w_byp, 16'h0000} : 32'h00000000;
      end
    end
  endgenerate

  // ************************************************************
  // lane registers
  // ************************************************************
  // lanes hold the last frame between valids; an unsupported mode sends nothing
  wire take = sample_valid && enable_q && supported;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lane_valid <= 1'b0;
      frame_cnt_q <= 16'h0000;
      for (int i = 0; i < lsm_pkg::LSM_LANES; i++) begin
        chan_a_lane[i] <= 32'h00000000;
        chan_b_lane[i] <= 32'h00000000;
      end
    end else begin
      lane_valid <= take;
      if (take) begin
        frame_cnt_q <= frame_cnt_q + 16'h0001;
        for (int i = 0; i < lsm_pkg::LSM_LANES; i++) begin
          chan_a_lane[i] <= lane_d[0][i];
          chan_b_lane[i] <= lane_d[1][i];
        end
      end
    end
  end

endmodule // lsm_top

`default_nettype wire

// >>> dv/lsm_chk_sva.sv
// checker for the lane sample mapper: bus handshakes and lane timing
// assumes it is bound into lsm_top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module lsm_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_valid,
  input wire logic lane_valid,
  input wire logic [7:0][31:0] chan_a_lane,
  input wire logic [7:0][31:0] chan_b_lane
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // both halves sit in their holding flops for one cycle, so bvalid comes two edges on
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_lane_cause: assert property (lane_valid |-> $past(sample_valid))
    else $error("lane word without frame");
  // a reset edge may clear the lanes, so that edge is excused
  a_lane_hold: assert property (!lane_valid && !$past(sys_rst) |-> $stable(chan_a_lane)
    && $stable(chan_b_lane)) else $error("lanes moved between frames");
  a_lane_low_zero: assert property (lane_valid |-> chan_a_lane[7][15:0] == 16'h0000
    && chan_b_lane[7][15:0] == 16'h0000) else $error("unused octets not zero");
endmodule // lsm_chk
bind lsm_top lsm_chk chk_u (.*);
`default_nettype wire

// >>> dv/lsm_rx_model.sv
// receiver-side model: captures every emitted frame of lane words
// assumes the lane outputs of lsm_top on the same clock
`timescale 1ns/100ps
`default_nettype none
module lsm_rx_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic lane_valid,
  input wire logic [7:0][31:0] chan_a_lane,
  input wire logic [7:0][31:0] chan_b_lane,
  output logic [7:0][31:0] rx_a_q,
  output logic [7:0][31:0] rx_b_q,
  output logic [15:0] rx_cnt_q
);
  // capture on the pulse only, so a held word is never taken twice
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_cnt_q <= 16'h0000;
    end else if (lane_valid) begin
      rx_a_q <= chan_a_lane;
      rx_b_q <= chan_b_lane;
      rx_cnt_q <= rx_cnt_q + 16'h0001;
    end
  end
endmodule // lsm_rx_model
`default_nettype wire

// >>> dv/tb_lane_sample_mapper.sv
// testbench: register access, every lane-map mode, refused frames
// assumes lsm_top, lsm_rx_model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module tb_lane_sample_mapper;
  logic clk = 1'b0, sys_rst = 1'b1, awv = 1'b0, wv = 1'b0, bdy = 1'b0, arv = 1'b0;
  logic rdy = 1'b0, sv = 1'b0, awr, wr, bv, arr, rv, lv;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0, rd, d;
  logic [3:0] ws = 4'h0, fa0 = 4'h0, fa1 = 4'h0, fb0 = 4'h0, fb1 = 4'h0;
  logic [1:0] br, rr, r;
  logic [59:0] ai = 60'h0, aq = 60'h0, bi = 60'h0, bq = 60'h0;
  logic [191:0] byp = 192'h0;
  logic [7:0][31:0] la, lb, xa, xb;
  logic [15:0] xc;
  int n_fail = 0, n_tests = 0, cyc = 0;
  logic [6:0] ml [19] = '{7'h0C, 7'h2F, 7'h0D, 7'h35, 7'h0E, 7'h27, 7'h38, 7'h3B, 7'h42,
    7'h44, 7'h0F, 7'h31, 7'h39, 7'h3C, 7'h43, 7'h10, 7'h37, 7'h3A, 7'h13};
  lsm_top dut_u (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bdy),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rdy), .sample_valid(sv),
    .chan_a_inphase_sample(ai), .chan_a_quadrature_sample(aq), .chan_b_inphase_sample(bi),
    .chan_b_quadrature_sample(bq), .chan_a_overrange_flag_first(fa0),
    .chan_a_overrange_flag_second(fa1), .chan_b_overrange_flag_first(fb0),
    .chan_b_overrange_flag_second(fb1), .bypass_sample(byp), .lane_valid(lv),
    .chan_a_lane(la), .chan_b_lane(lb));
  lsm_rx_model rx_u (.clk(clk), .sys_rst(sys_rst), .lane_valid(lv), .chan_a_lane(la),
    .chan_b_lane(lb), .rx_a_q(xa), .rx_b_q(xb), .rx_cnt_q(xc));
  // ********
  // tasks
  // ********
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge clk);
    aw <= a;
    wd <= v;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bdy <= 1'b1;
    forever begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    r = br;
    bdy <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    ar <= a;
    arv <= 1'b1;
    rdy <= 1'b1;
    forever begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    d = rd;
    r = rr;
    rdy <= 1'b0;
  endtask
  // one frame with fresh inputs; the answer comes one edge after it is taken
  task automatic frame(input int n, input logic e);
    @(posedge clk);
    sv <= 1'b1;
    ai <= 60'h123456789ABCDEF + 60'(n);
    aq <= 60'h0F1E2D3C4B5A697 - 60'(n);
    bi <= 60'hA5A5A5A5A5A5A5A + 60'(n);
    bq <= 60'h5A5A5A5A5A5A5A5 + 60'(n);
    fa0 <= 4'(n);
    fa1 <= ~4'(n);
    fb0 <= 4'(n + 5);
    fb1 <= 4'(n * 3);
    byp <= {4{48'hF123456789AB}} + 192'(n);
    @(posedge clk);
    sv <= 1'b0;
    @(posedge clk);
    chk("lane_valid", {31'h0, e}, {31'h0, lv});
    @(posedge clk);
  endtask
  function automatic logic [31:0] exl(input logic [6:0] m, input int c, input int i);
    logic [59:0] s0;
    logic [59:0] s1;
    logic [3:0] f0;
    logic [3:0] f1;
    logic [47:0] g;
    s0 = c ? bi : ai;
    s1 = c ? bq : aq;
    f0 = c ? fb0 : fa0;
    f1 = c ? fb1 : fa1;
    g = 48'h0;
    for (int t = 0; t < 4; t++) begin
      if (i < 6) g[47 - 12 * t -: 12] = byp[96 * (i / 3) + 12 * c + 24 * t +: 12];
    end
    case (m)
      7'h13: return {g[47 - 16 * (i % 3) -: 16], 16'h0000};
      7'h0D, 7'h35: return i == 0 ? {s0[14:0], f0[0], s1[14:0], f1[0]} : 32'h0;
      7'h0E, 7'h27, 7'h38, 7'h3B, 7'h42, 7'h44: return i == 0 ? {s0[14:0], f0[0], 16'h0000}
        : i == 1 ? {s1[14:0], f1[0], 16'h0000} : 32'h0;
      7'h0F, 7'h31, 7'h39, 7'h3C, 7'h43: return i < 2 ? {s0[15 * i +: 15], f0[i], 16'h0000}
        : i < 4 ? {s1[15 * (i - 2) +: 15], f1[i - 2], 16'h0000} : 32'h0;
      default: return i < 4 ? {s0[15 * i +: 15], f0[i], 16'h0000}
        : {s1[15 * (i - 4) +: 15], f1[i - 4], 16'h0000};
    endcase
  endfunction
  // ********
  // sequence
  // ********
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rd_reg(8'h00);
    chk("ctrl", 32'h0000010C, d);
    rd_reg(8'h04);
    chk("status", 32'h00001001, d);
    $display("test reset done");
    for (int n = 0; n < 19; n++) begin
      wr_reg(8'h00, 32'h00000100 | 32'(ml[n]), 4'h3);
      chk("bresp", 32'h0, 32'(r));
      frame(n, 1'b1);
      for (int i = 0; i < 16; i++) begin
        chk("lane", exl(ml[n], i / 8, i % 8), i < 8 ? xa[i] : xb[i - 8]);
      end
    end
    rd_reg(8'h04);
    chk("status", 32'h00130C01, d);
    $display("test modes done");
    wr_reg(8'h00, 32'h0000000C, 4'h3);
    frame(0, 1'b0);
    wr_reg(8'h00, 32'h00000113, 4'h1);
    rd_reg(8'h00);
    chk("ctrl", 32'h00000013, d);
    wr_reg(8'h08, 32'h00000100, 4'hF);
    chk("bresp", 32'h2, 32'(r));
    wr_reg(8'h04, 32'h00000000, 4'hF);
    chk("bresp", 32'h0, 32'(r));
    rd_reg(8'h0C);
    chk("rresp", 32'h2, 32'(r));
    chk("rdata", 32'h0, d);
    wr_reg(8'h00, 32'h00000100, 4'h3);
    frame(1, 1'b0);
    rd_reg(8'h04);
    chk("status", 32'h00130000, d);
    chk("frames", 32'd19, 32'(xc));
    $display("test refusals done");
    stop_test();
  end
endmodule // tb_lane_sample_mapper
`default_nettype wire
